//--- inc/scu_pkg.sv
// Constants and types for the stream cipher unit
package scu_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register word addresses
  localparam logic [11:0] A_CTRL = 12'h400;
  localparam logic [11:0] A_STAT = 12'h401;
  localparam logic [11:0] A_ICLR = 12'h402;
  localparam logic [11:0] A_KLEN = 12'h403;
  localparam logic [11:0] A_KEY0 = 12'h404;
  localparam logic [11:0] A_KEY3 = 12'h407;
  localparam logic [11:0] A_MCNT = 12'h408;
  localparam logic [11:0] A_IN = 12'h409;
  localparam logic [11:0] A_OUT = 12'h40A;
  localparam logic [11:0] A_PTR = 12'h40B;
  localparam logic [11:0] A_SBOX0 = 12'h410;
  localparam logic [11:0] A_SBOXL = 12'h50C;

  // Control fields
  localparam int C_SRST = 30;
  localparam int C_MASK = 31;

  // Status fields
  localparam int S_EMPTY = 25;
  localparam int S_FULL = 26;
  localparam int S_SUB = 27;
  localparam int S_PERM = 28;
  localparam int S_INIT = 29;
  localparam int S_IRQ = 30;
  localparam int S_BUSY = 31;

  // Sub-message count fields
  localparam int M_LAST = 2;
  localparam int M_CNT_HI = 1;

  // Pointer register fields
  localparam int P_I_LSB = 0;
  localparam int P_J_LSB = 8;

  // Reset values and last S-box index
  localparam logic [2:0] MCNT_RST = 3'h3;
  localparam logic [3:0] KLEN_RST = 4'hF;
  localparam logic MASK_RST = 1'b1;
  localparam logic [7:0] LAST_IDX = 8'hFF;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scu_req_s;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_INIT_DONE,
    ST_PERM,
    ST_READY,
    ST_MSG
  } scu_state_e;

endpackage

//--- logic/scu_stream_cipher_unit.sv
// Stream cipher unit: register file, key schedule and byte stream core
//
// Behaviour
// - Control bit 30 resets the unit like hardware reset, self-clearing.
// - Control bit 31 masks the interrupt pin, never the status flag.
// - Every reset sets the interrupt mask bit.
// - Any write to interrupt clear drops pin and status flag, unless a completion sets the flag in the same cycle.
// - Key length is four write-only bits, bytes minus one.
// - Writing key length starts permuting the S-box with the key.
// - Key held in four write-only words, low word least significant.
// - Count register holds last flag and final byte count minus one.
// - Sub-messages are four bytes unless a shorter count is set.
// - After the last sub-message the unit restarts initialisation.
// - Writing the input word starts processing that sub-message.
// - Output word holds the processed sub-message, valid once done.
// - Unprocessed output bytes equal the input word bytes.
// - Pointer register holds i and j, accessible while idle.
// - S-box is 64 read/write words, accessible while idle.
// - Status interrupt flag set on each of four completions.
// - Full message done stays until new key or output read.
// - Input empty set with no word pending, cleared by a write.
// - Busy flag set whenever the core is not idle.
`timescale 1ns/10ps
`default_nettype none

module scu_stream_cipher_unit (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire scu_pkg::scu_req_s i_req,
  output logic [31:0] o_rd_data,
  output logic o_irq_n
);
  import scu_pkg::*;

  function automatic logic sbox_hit(input logic [11:0] a);
    return (a >= A_SBOX0) && (a <= A_SBOXL) && (a[1:0] == 2'h0);
  endfunction

  logic srst;
  logic mask;
  logic irq;
  logic in_empty;
  logic full_done;
  logic sub_done;
  logic perm_done;
  logic init_done;
  logic perm_req;
  logic [127:0] key;
  logic [3:0] klen;
  logic [2:0] mcnt;
  logic [31:0] in_buf;
  logic [31:0] work;
  logic [31:0] out_word;
  logic [7:0] sbox [256];
  scu_state_e st;
  logic [7:0] k;
  logic [7:0] pi;
  logic [7:0] pj;
  logic [3:0] kb;
  logic [1:0] bidx;
  logic [31:0] next_rd;
  logic [31:0] next_work;

  wire logic rst_all = i_rst | srst;

  // Register decode
  wire logic wr = i_req.wr;
  wire logic rd = i_req.rd;
  wire logic [11:0] addr = i_req.addr;
  wire logic [31:0] wdata = i_req.wdata;
  wire logic w_ctrl = wr && (addr == A_CTRL);
  wire logic w_iclr = wr && (addr == A_ICLR);
  wire logic w_klen = wr && (addr == A_KLEN);
  wire logic w_key = wr && (addr >= A_KEY0) && (addr <= A_KEY3);
  wire logic w_mcnt = wr && (addr == A_MCNT);
  wire logic w_in = wr && (addr == A_IN);
  wire logic r_out = rd && (addr == A_OUT);
  wire logic [1:0] key_sel = 2'(addr - A_KEY0);
  wire logic [5:0] sb_w = 6'((addr - A_SBOX0) >> 2);

  wire logic idle = (st == ST_INIT_DONE) || (st == ST_READY);
  wire logic busy = !idle;

  wire logic sb_wr = wr && sbox_hit(addr) && idle;
  wire logic ptr_wr = wr && (addr == A_PTR) && idle;

  // Permutation step
  wire logic [7:0] s_k = sbox[k];
  wire logic [7:0] key_b = key[{kb, 3'h0} +: 8];
  wire logic [7:0] pj_n = 8'(pj + s_k + key_b);

  // Keystream step
  wire logic [7:0] ii = 8'(pi + 8'h01);
  wire logic [7:0] si = sbox[ii];
  wire logic [7:0] jn = 8'(pj + si);
  wire logic [7:0] sj = sbox[jn];
  wire logic [7:0] t = 8'(si + sj);
  wire logic [7:0] ks = (t == ii) ? sj : (t == jn) ? si : sbox[t];

  // Events and starts
  wire logic ev_init = (st == ST_INIT) && (k == LAST_IDX);
  wire logic ev_perm = (st == ST_PERM) && (k == LAST_IDX);
  wire logic ev_sub = (st == ST_MSG) && (bidx == mcnt[M_CNT_HI:0]);
  wire logic ev_full = ev_sub && mcnt[M_LAST];
  wire logic start_perm = perm_req && (st == ST_INIT_DONE);
  wire logic start_msg = !in_empty && (st == ST_READY) && !w_klen;
  wire logic abort = w_klen && (st != ST_INIT) && (st != ST_INIT_DONE);
  wire logic irq_set = ev_init || ev_perm || ev_sub;

  always_comb begin
    next_work = work;
    next_work[{bidx, 3'h0} +: 8] = work[{bidx, 3'h0} +: 8] ^ ks;
  end

  // Read mux
  always_comb begin
    next_rd = 32'h0000_0000;
    if (addr == A_CTRL) begin
      next_rd[C_MASK] = mask;
      next_rd[C_SRST] = srst;
    end else if (addr == A_STAT) begin
      next_rd[S_BUSY] = busy;
      next_rd[S_IRQ] = irq;
      next_rd[S_INIT] = init_done;
      next_rd[S_PERM] = perm_done;
      next_rd[S_SUB] = sub_done;
      next_rd[S_FULL] = full_done;
      next_rd[S_EMPTY] = in_empty;
    end else if (addr == A_OUT) begin
      next_rd = out_word;
    end else if (addr == A_PTR && idle) begin
      next_rd[P_I_LSB +: 8] = pi;
      next_rd[P_J_LSB +: 8] = pj;
    end else if (sbox_hit(addr) && idle) begin
      for (int b = 0; b < 4; b++) begin
        next_rd[8*b +: 8] = sbox[{sb_w, 2'(b)}];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rd) begin
      o_rd_data <= next_rd;
    end else begin
      o_rd_data <= 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      srst <= 1'b0;
    end else begin
      srst <= w_ctrl && wdata[C_SRST];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= !(irq && !mask);
    end
  end

  // Control and host fields
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      mask <= MASK_RST;
      key <= '0;
      klen <= KLEN_RST;
      in_buf <= 32'h0000_0000;
    end else begin
      if (w_ctrl) begin
        mask <= wdata[C_MASK];
      end
      if (w_key) begin
        key[{key_sel, 5'h00} +: 32] <= wdata;
      end
      if (w_klen) begin
        klen <= wdata[3:0];
      end
      if (w_in) begin
        in_buf <= wdata;
      end
    end
  end

  // Status flags; setting wins over clearing, except input empty, where clearing by a write wins
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      irq <= 1'b0;
      in_empty <= 1'b1;
      full_done <= 1'b0;
      sub_done <= 1'b0;
      perm_done <= 1'b0;
      init_done <= 1'b0;
      perm_req <= 1'b0;
    end else begin
      irq <= irq_set || (irq && !w_iclr);
      in_empty <= w_in ? 1'b0 : (start_msg ? 1'b1 : in_empty);
      full_done <= ev_full || (full_done && !w_key && !w_klen && !r_out);
      sub_done <= ev_sub || (sub_done && !start_msg && !abort);
      perm_done <= ev_perm || (perm_done && !start_msg && !abort);
      init_done <= ev_init || (init_done && !start_perm);
      perm_req <= w_klen || (perm_req && !start_perm);
    end
  end

  // Core sequencer
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      st <= ST_INIT;
      k <= 8'h00;
      pi <= 8'h00;
      pj <= 8'h00;
      kb <= 4'h0;
      bidx <= 2'h0;
      mcnt <= MCNT_RST;
      work <= 32'h0000_0000;
      out_word <= 32'h0000_0000;
    end else begin
      if (w_mcnt) begin
        mcnt <= wdata[2:0];
      end
      if (ptr_wr) begin
        pi <= wdata[P_I_LSB +: 8];
        pj <= wdata[P_J_LSB +: 8];
      end
      case (st)
        ST_INIT: begin
          k <= 8'(k + 8'h01);
          if (k == LAST_IDX) begin
            st <= ST_INIT_DONE;
          end
        end
        ST_INIT_DONE: begin
          if (start_perm) begin
            st <= ST_PERM;
            k <= 8'h00;
            pj <= 8'h00;
            kb <= 4'h0;
          end
        end
        ST_PERM: begin
          k <= 8'(k + 8'h01);
          pj <= pj_n;
          kb <= (kb == klen) ? 4'h0 : 4'(kb + 4'h1);
          if (k == LAST_IDX) begin
            st <= ST_READY;
            pi <= 8'h00;
            pj <= 8'h00;
          end
        end
        ST_READY: begin
          if (start_msg) begin
            st <= ST_MSG;
            work <= in_buf;
            bidx <= 2'h0;
          end
        end
        ST_MSG: begin
          pi <= ii;
          pj <= jn;
          work <= next_work;
          bidx <= 2'(bidx + 2'h1);
          if (ev_sub) begin
            out_word <= next_work;
            st <= ST_READY;
            if (ev_full) begin
              st <= ST_INIT;
              k <= 8'h00;
              pi <= 8'h00;
              pj <= 8'h00;
              mcnt <= MCNT_RST;
            end
          end
        end
        default: begin
          st <= ST_INIT;
          k <= 8'h00;
        end
      endcase
      // New key length while keyed: reinitialise first
      if (abort) begin
        st <= ST_INIT;
        k <= 8'h00;
      end
    end
  end

  // S-box storage
  always_ff @(posedge i_sys_clk) begin
    if (st == ST_INIT) begin
      sbox[k] <= k;
    end else if (st == ST_PERM) begin
      sbox[k] <= sbox[pj_n];
      sbox[pj_n] <= s_k;
    end else if (st == ST_MSG) begin
      sbox[ii] <= sj;
      sbox[jn] <= si;
    end else if (sb_wr) begin
      for (int b = 0; b < 4; b++) begin
        sbox[{sb_w, 2'(b)}] <= wdata[8*b +: 8];
      end
    end
  end

endmodule // scu_stream_cipher_unit

`default_nettype wire

//--- testbench/scu_checker_assertions.sv
// Port checks for the stream cipher unit
`timescale 1ns/10ps
`default_nettype none
module scu_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire scu_pkg::scu_req_s i_req,
  input wire logic [31:0] o_rd_data,
  input wire logic o_irq_n
);
  import scu_pkg::*;
  logic mask_q;
  logic srst_d;
  wire ctrl_wr = i_req.wr && i_req.addr == A_CTRL;
  always_ff @(posedge i_sys_clk) begin
    srst_d <= !i_rst && ctrl_wr && i_req.wdata[C_SRST];
    if (i_rst || srst_d) begin
      mask_q <= 1'b1;
    end else if (ctrl_wr) begin
      mask_q <= i_req.wdata[C_MASK];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_RD_IDLE_ZERO: assert property (
    !$past(i_req.rd) |-> o_rd_data == 32'h0) else $error("stray read data");
  AST_HW_RST_PIN: assert property (
    $fell(i_rst) |-> o_irq_n ##1 o_irq_n) else $error("pin low after reset");
  AST_SRST_PIN: assert property (
    ctrl_wr && i_req.wdata[C_SRST] |-> ##3 o_irq_n [*8])
    else $error("pin low after soft reset");
  AST_CLR_PIN: assert property (
    i_req.wr && i_req.addr == A_ICLR |-> ##3 o_irq_n)
    else $error("pin not cleared");
  AST_MASK_PIN: assert property (
    mask_q && $past(mask_q) && $past(mask_q, 2) |-> o_irq_n)
    else $error("masked pin low");
  AST_PIN_MATCH: assert property (
    $past(i_req.rd) && $past(i_req.addr) == A_STAT && $stable(mask_q)
    |-> o_irq_n == !(o_rd_data[S_IRQ] && !mask_q))
    else $error("pin and flag differ");
  AST_WO_READ_ZERO: assert property (
    $past(i_req.rd) && $past(i_req.addr) >= A_ICLR
    && $past(i_req.addr) <= A_IN |-> o_rd_data == 32'h0)
    else $error("write-only reads nonzero");
  AST_CTRL_READ: assert property (
    $past(i_req.rd) && $past(i_req.addr) == A_CTRL && !$past(srst_d)
    |-> o_rd_data == {$past(mask_q), 31'h0}) else $error("control readback");
endmodule // scu_checker
`default_nettype wire

//--- testbench/scu_host_model.sv
// Host bus master for the register port
`timescale 1ns/10ps
`default_nettype none
module scu_host_model (
  input wire logic i_sys_clk,
  output var scu_pkg::scu_req_s o_req
);
  import scu_pkg::*;
  initial o_req = '0;
  task automatic access(input logic [11:0] a, input logic [31:0] d,
                        input logic w);
    @(posedge i_sys_clk);
    o_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge i_sys_clk);
    o_req <= '0;
  endtask
endmodule // scu_host_model
`default_nettype wire

//--- testbench/scu_stream_cipher_unit_tb_top.sv
// Self-checking bench for the stream cipher unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin \
  fail_count++; $display("[FAIL] %0t got %h want %h", $time, act, exp); \
  end end
module scu_stream_cipher_unit_tb_top;
  import scu_pkg::*;
  logic i_sys_clk;
  logic i_rst;
  scu_req_s req;
  logic [31:0] o_rd_data;
  logic o_irq_n;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0001_0514;
  logic [63:0] expq [$];
  logic [63:0] ent;
  logic rd_d = 1'b0;
  logic [7:0] sb [256];
  logic [7:0] kb [16];
  logic [7:0] pi;
  logic [7:0] pj;
  logic [31:0] w;
  logic [3:0] kl;
  scu_host_model u_scu_host_model (.i_sys_clk(i_sys_clk), .o_req(req));
  scu_stream_cipher_unit u_scu_stream_cipher_unit (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_req(req), .o_rd_data(o_rd_data), .o_irq_n(o_irq_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic ksa(input int n);
    logic [7:0] j;
    logic [7:0] t;
    j = 8'h00;
    for (int k = 0; k < 256; k++) sb[k] = 8'(k);
    for (int k = 0; k < 256; k++) begin
      j = j + sb[k] + kb[k % n];
      t = sb[k];
      sb[k] = sb[j];
      sb[j] = t;
    end
    pi = 8'h00;
    pj = 8'h00;
  endtask
  function automatic logic [31:0] enc(input logic [31:0] d, input int nb);
    logic [7:0] t;
    for (int b = 0; b < nb; b++) begin
      pi++;
      pj += sb[pi];
      t = sb[pi];
      sb[pi] = sb[pj];
      sb[pj] = t;
      d[8*b +: 8] ^= sb[sb[pi] + sb[pj]];
    end
    return d;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_scu_host_model.access(a, d, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    expq.push_back({m, e & m});
    u_scu_host_model.access(a, 32'h0, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    rd_d <= req.rd;
    if (rd_d) begin
      ent = expq.pop_front();
      `CHK(o_rd_data & ent[63:32], ent[31:0])
    end
  end
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    i_rst = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(A_CTRL, 32'h8000_0000, '1);
    rd(A_STAT, 32'h8200_0000, '1);
    rd(A_SBOX0, 32'h0, '1);
    rd(12'h3FF, 32'h0, '1);
    repeat (270) @(posedge i_sys_clk);
    rd(A_STAT, 32'h6200_0000, '1);
    rd(A_SBOX0, 32'h0302_0100, '1);
    rd(A_SBOXL, 32'hFFFE_FDFC, '1);
    wr(A_CTRL, 32'h0);
    repeat (3) @(posedge i_sys_clk);
    `CHK(o_irq_n, 1'b0)
    wr(A_ICLR, rnd());
    rd(A_STAT, 32'h2200_0000, '1);
    // key words low first, length last
    for (int m = 0; m < 4; m++) begin
      w = rnd();
      wr(12'(A_KEY0 + m), w);
      for (int b = 0; b < 4; b++) kb[4*m+b] = w[8*b +: 8];
    end
    kl = 4'(rnd() % 16);
    wr(A_KLEN, {28'h0, kl});
    rd(A_STAT, 32'h8000_0000, 32'h8000_0000);
    repeat (270) @(posedge i_sys_clk);
    ksa(kl + 1);
    rd(A_STAT, 32'h5200_0000, '1);
    w = rnd();
    wr(A_IN, w);
    repeat (12) @(posedge i_sys_clk);
    rd(A_OUT, enc(w, 4), '1);
    wr(A_MCNT, 32'h5);
    w = rnd();
    wr(A_IN, w);
    // word written while busy stays pending
    wr(A_IN, rnd());
    rd(A_STAT, 32'h0, 32'h0200_0000);
    repeat (12) @(posedge i_sys_clk);
    rd(A_STAT, 32'h0400_0000, 32'h0400_0000);
    rd(A_OUT, enc(w, 2), '1);
    rd(A_STAT, 32'h0, 32'h0400_0000);
    repeat (270) @(posedge i_sys_clk);
    rd(A_STAT, 32'h2000_0000, 32'hA000_0000);
    w = rnd();
    wr(A_PTR, w);
    rd(A_PTR, {16'h0, w[15:0]}, '1);
    w = rnd();
    wr(12'h424, w);
    rd(12'h424, w, '1);
    wr(A_CTRL, 32'hC000_0000);
    repeat (3) @(posedge i_sys_clk);
    rd(A_CTRL, 32'h8000_0000, '1);
    rd(A_STAT, 32'h8200_0000, 32'h8200_0000);
    rd(A_PTR, 32'h0, '1);
    repeat (10) @(posedge i_sys_clk);
    tally_and_finish();
  end
endmodule // scu_stream_cipher_unit_tb_top
bind scu_stream_cipher_unit scu_checker u_scu_checker (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(i_req),
  .o_rd_data(o_rd_data), .o_irq_n(o_irq_n));
`undef CHK
`default_nettype wire
